// ### rtl/mra_defines.vh
/*
 * Register map, field positions and reset values of the monitor register bank.
 * Assumes inclusion by bare name from the rtl folder.
 */
`ifndef MRA_DEFINES_VH
`define MRA_DEFINES_VH

// ********************************
// Register offsets (6-bit address space)
// ********************************
`define MRA_ADDR_DEVICE_NUMBER   6'h00
`define MRA_ADDR_DEVICE_CONTROL  6'h05
`define MRA_ADDR_VOLTAGE_CONTROL 6'h12
`define MRA_ADDR_RSVD_A_LO       6'h13
`define MRA_ADDR_RSVD_A_HI       6'h1f
`define MRA_ADDR_CONV_RATE       6'h20
`define MRA_ADDR_UNDEF_B_LO      6'h21

// ********************************
// Fields and reset values
// ********************************
`define MRA_ADDR_SEL_LOW         3'h1
`define MRA_ADDR_SEL_HIGH        3'h7
`define MRA_CTRL_RESET_BIT       0
`define MRA_VOLT_CTRL_RESET      16'h001f
`define MRA_VOLT_CTRL_MASK       16'h07ff
`define MRA_CONV_RATE_RESET      16'h0002
`define MRA_CONV_RATE_MASK       16'h0003
`define MRA_DEV_CTRL_RESET       16'h0000
`define MRA_RESTART_CYCLES       4'h4

`endif

// ### rtl/mra_sync2.v
/*
 * Two flip-flop synchroniser for one level.
 * Assumes the input is asynchronous to ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module mra_sync2 (
	// Clock and reset
	input  wire ref_clk,
	input  wire rst,
	// Level
	input  wire d_async,
	output reg  q_sync
);

	reg stage_one;

	always @(posedge ref_clk) begin
		if (rst) begin
			stage_one <= 1'b0;
			q_sync    <= 1'b0;
		end else begin
			stage_one <= d_async;
			q_sync    <= stage_one;
		end
	end

endmodule // mra_sync2

`default_nettype wire

// ### rtl/mra_monitor_regs.v
/*
 * Device-level register bank of the hardware monitor: device reset sequence,
 * device number from the address strap, control and rate registers.
 * Assumes a bus front end delivering single-cycle read and write strobes with
 * a 6-bit register address and 16-bit data, all on ref_clk.
 */
// Contract
// - Full device reset at power-up and when the control reset bit is written one.
// - Writing one to the control reset bit triggers device reset; host may use it.
// - Device reset aborts operation in progress and restarts normal operation.
// - Device reset loads every register with its default value.
// - Device number register presents this device's bus address.
// - Address select reads 001 when strap low, 111 when strap high.
// - Address select follows the strap continuously, no reset needed.
// - Device number is read-only; writes are ignored.
`timescale 1ns/100ps
`default_nettype none
`include "mra_defines.vh"

module mra_monitor_regs #(
	parameter [3:0] RESTART_CYCLES = `MRA_RESTART_CYCLES
) (
	// Clock and power-up reset
	input  wire        ref_clk,
	input  wire        rst,
	// Address strap pin
	input  wire        addr_strap,
	// Register access
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [5:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	output reg  [15:0] reg_rdata,
	output reg         reg_rvalid,
	// Device operation control
	output reg         dev_reset_busy,
	output reg         dev_run,
	output reg  [15:0] voltage_control,
	output reg  [15:0] conversion_rate,
	output reg  [2:0]  address_select_field
);

	// ********************************
	// Device states
	// ********************************
	localparam [1:0] ST_RESET = 2'b01;
	localparam [1:0] ST_RUN   = 2'b10;

	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg  [3:0]  restart_cnt;
	reg  [3:0]  next_cnt;
	reg         next_busy;
	reg         next_run;
	reg  [15:0] next_voltage;
	reg  [15:0] next_rate;
	reg  [2:0]  next_select;
	reg  [15:0] next_rdata;
	wire        strap_sync;
	wire        soft_reset;
	wire        run_write;
	wire        hit_control;
	wire        hit_voltage;
	wire        hit_rate;

	// ********************************
	// Strap synchroniser
	// ********************************
	mra_sync2 u_strap_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.d_async (addr_strap),
		.q_sync  (strap_sync)
	);

	// ********************************
	// Address decode
	// ********************************
	assign hit_control = (reg_addr == `MRA_ADDR_DEVICE_CONTROL);
	assign hit_voltage = (reg_addr == `MRA_ADDR_VOLTAGE_CONTROL);
	assign hit_rate    = (reg_addr == `MRA_ADDR_CONV_RATE);

	assign soft_reset = reg_wr && hit_control && reg_wdata[`MRA_CTRL_RESET_BIT];

	// Voltage and rate writes only land while normal operation runs
	assign run_write = reg_wr && (state == ST_RUN);

	// ********************************
	// Reset sequencer
	// ********************************
	// Counts down idle edges before normal operation resumes
	always @* begin
		next_state = state;
		next_cnt   = restart_cnt;
		next_busy  = dev_reset_busy;
		next_run   = dev_run;
		case (state)
			ST_RESET: begin
				if (restart_cnt == 4'h0) begin
					next_state = ST_RUN;
					next_busy  = 1'b0;
					next_run   = 1'b1;
				end else begin
					next_cnt  = restart_cnt - 4'h1;
					next_busy = 1'b1;
					next_run  = 1'b0;
				end
			end
			ST_RUN: begin
				next_busy = 1'b0;
				next_run  = 1'b1;
			end
			default: begin
				next_state = ST_RESET;
				next_cnt   = RESTART_CYCLES;
				next_busy  = 1'b1;
				next_run   = 1'b0;
			end
		endcase
		// abort and restart
		// A reset write wins over the count ending in the same cycle
		if (soft_reset) begin
			next_state = ST_RESET;
			next_cnt   = RESTART_CYCLES;
			next_busy  = 1'b1;
			next_run   = 1'b0;
		end
	end

	// power-up and soft reset
	// Status outputs come straight from flops so the host sees clean levels
	always @(posedge ref_clk) begin
		if (rst) begin
			state          <= ST_RESET;
			restart_cnt    <= RESTART_CYCLES;
			dev_reset_busy <= 1'b1;
			dev_run        <= 1'b0;
		end else begin
			state          <= next_state;
			restart_cnt    <= next_cnt;
			dev_reset_busy <= next_busy;
			dev_run        <= next_run;
		end
	end

	// ********************************
	// Writable registers
	// ********************************
	// Reserved and undefined writes fall through untouched
	always @* begin
		next_voltage = voltage_control;
		next_rate    = conversion_rate;
		if (run_write && hit_voltage)
			next_voltage = reg_wdata & `MRA_VOLT_CTRL_MASK;
		if (run_write && hit_rate)
			next_rate = reg_wdata & `MRA_CONV_RATE_MASK;
	end

	always @(posedge ref_clk) begin
		if (rst || soft_reset) begin
			voltage_control <= `MRA_VOLT_CTRL_RESET;
			conversion_rate <= `MRA_CONV_RATE_RESET;
		end else begin
			voltage_control <= next_voltage;
			conversion_rate <= next_rate;
		end
	end

	// ********************************
	// Device number
	// ********************************
	// strap decode
	always @* begin
		if (strap_sync)
			next_select = `MRA_ADDR_SEL_HIGH;
		else
			next_select = `MRA_ADDR_SEL_LOW;
	end

	// tracks strap always
	// The field follows the pin in normal operation and through a soft reset alike
	always @(posedge ref_clk) begin
		if (rst)
			address_select_field <= `MRA_ADDR_SEL_LOW;
		else
			address_select_field <= next_select;
	end

	// ********************************
	// Read path
	// ********************************
	always @* begin
		next_rdata = 16'h0000;
		case (reg_addr)
			`MRA_ADDR_DEVICE_NUMBER:   next_rdata = {13'h0000, address_select_field};
			`MRA_ADDR_DEVICE_CONTROL:  next_rdata = `MRA_DEV_CTRL_RESET;
			`MRA_ADDR_VOLTAGE_CONTROL: next_rdata = voltage_control;
			`MRA_ADDR_CONV_RATE:       next_rdata = conversion_rate;
			// Reserved and undefined addresses read zero
			default:                   next_rdata = 16'h0000;
		endcase
	end

	// no write path to device number
	// Read data holds between reads so a slow host may sample it late
	always @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= next_rdata;
		end
	end

endmodule // mra_monitor_regs

`default_nettype wire

// ### testbench/mra_monitor_regs_chk.sv
/* Port checker of the monitor register bank.
   Assumes binding onto mra_monitor_regs. */
`timescale 1ns/100ps
`default_nettype none
module mra_chk #(
	parameter [3:0] RESTART_CYCLES = 4'h4
) (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// Strap pin
	input wire logic        addr_strap,
	// Register access
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [5:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_rvalid,
	// Device operation
	input wire logic        dev_reset_busy,
	input wire logic        dev_run,
	input wire logic [15:0] voltage_control,
	input wire logic [15:0] conversion_rate,
	input wire logic [2:0]  address_select_field
);
	localparam int RC1 = RESTART_CYCLES + 1;
	wire sw = reg_wr && reg_addr == 6'h05 && reg_wdata[0] && dev_run;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_BUSY: assert property (sw |=> dev_reset_busy && !dev_run) else $error("busy");
	AST_RUN: assert property ($rose(dev_reset_busy) |-> ##RC1 dev_run && !dev_reset_busy)
		else $error("run");
	AST_DEF: assert property (sw |=> voltage_control == 16'h001f && conversion_rate == 16'h0002)
		else $error("defaults");
	AST_ABORT: assert property (dev_reset_busy |-> !dev_run) else $error("abort");
	AST_IGN: assert property (dev_reset_busy && reg_wr |=> voltage_control == 16'h001f)
		else $error("write in reset");
	AST_SEL: assert property ($stable(addr_strap) [*4] |->
		address_select_field == (addr_strap ? 3'h7 : 3'h1)) else $error("select");
	AST_TRK: assert property ($rose(addr_strap) |-> ##[1:4] address_select_field == 3'h7)
		else $error("track");
	AST_NUM: assert property (reg_rd && reg_addr == 6'h00 |=> reg_rvalid &&
		reg_rdata == {13'h0000, $past(address_select_field)}) else $error("number");
	cover property (sw);
	cover property ($rose(addr_strap));
	cover property (reg_rd && reg_addr == 6'h00);
	cover property ($rose(dev_run));
endmodule // mra_chk
bind mra_monitor_regs mra_chk #(.RESTART_CYCLES(RESTART_CYCLES)) i_chk (
	.ref_clk              (ref_clk),
	.rst                  (rst),
	.addr_strap           (addr_strap),
	.reg_wr               (reg_wr),
	.reg_rd               (reg_rd),
	.reg_addr             (reg_addr),
	.reg_wdata            (reg_wdata),
	.reg_rdata            (reg_rdata),
	.reg_rvalid           (reg_rvalid),
	.dev_reset_busy       (dev_reset_busy),
	.dev_run              (dev_run),
	.voltage_control      (voltage_control),
	.conversion_rate      (conversion_rate),
	.address_select_field (address_select_field)
);
`default_nettype wire

// ### testbench/mra_host.sv
/* Host model issuing one-cycle strobes.
   Assumes the bank samples them on the rising edge. */
`timescale 1ns/100ps
`default_nettype none
module mra_host (
	input  wire logic        ref_clk, reg_rvalid,
	input  wire logic [15:0] reg_rdata,
	output var  logic        reg_wr = 0, reg_rd = 0,
	output var  logic [5:0]  reg_addr = 6'h3f,
	output var  logic [15:0] reg_wdata = 16'h0
);
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(negedge ref_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge ref_clk) {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [5:0] a, output logic [15:0] d);
		@(negedge ref_clk) {reg_rd, reg_addr} = {1'b1, a};
		@(negedge ref_clk);
		// Valid pulses for one cycle; read data holds after it until the next read
		d = reg_rvalid ? reg_rdata : 16'hxxxx;
		{reg_rd, reg_addr} = {1'b0, ~a};
	endtask
endmodule // mra_host
`default_nettype wire

// ### testbench/testbench.sv
/* Self-checking bench of the monitor register bank.
   Assumes the host model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,s) begin checked++; if ((s) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
	logic        ref_clk = 0, rst = 1, addr_strap = 0, reg_wr, reg_rd, reg_rvalid;
	logic        dev_reset_busy, dev_run;
	logic [5:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, voltage_control, conversion_rate, v;
	logic [2:0]  address_select_field;
	int          errors = 0, checked = 0;
	mra_monitor_regs i_dut (
		.ref_clk              (ref_clk),
		.rst                  (rst),
		.addr_strap           (addr_strap),
		.reg_wr               (reg_wr),
		.reg_rd               (reg_rd),
		.reg_addr             (reg_addr),
		.reg_wdata            (reg_wdata),
		.reg_rdata            (reg_rdata),
		.reg_rvalid           (reg_rvalid),
		.dev_reset_busy       (dev_reset_busy),
		.dev_run              (dev_run),
		.voltage_control      (voltage_control),
		.conversion_rate      (conversion_rate),
		.address_select_field (address_select_field)
	);
	mra_host i_host (
		.ref_clk    (ref_clk),
		.reg_rvalid (reg_rvalid),
		.reg_rdata  (reg_rdata),
		.reg_wr     (reg_wr),
		.reg_rd     (reg_rd),
		.reg_addr   (reg_addr),
		.reg_wdata  (reg_wdata)
	);
	initial forever #5 ref_clk = ~ref_clk;
	task automatic conclude;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wait_run;
		for (int i = 0; i < 20 && dev_run !== 1'b1; i++) @(negedge ref_clk);
		if (dev_run !== 1'b1) begin errors++; conclude; end
	endtask
	task automatic t_power;
		wait_run;
		`CHK("volt", 16'h001f, voltage_control)
		`CHK("rate", 16'h0002, conversion_rate)
		i_host.rd(6'h00, v);
		`CHK("devnum", 16'h0001, v)
		i_host.rd(6'h13, v);
		`CHK("rsvd", 16'h0000, v)
	endtask
	task automatic t_soft;
		i_host.wr(6'h12, 16'hffff);
		i_host.wr(6'h20, 16'hffff);
		`CHK("volt w", 16'h07ff, voltage_control)
		`CHK("rate w", 16'h0003, conversion_rate)
		i_host.wr(6'h05, 16'h0001);
		i_host.wr(6'h12, 16'h0000);
		`CHK("busy", 1'b1, dev_reset_busy)
		wait_run;
		`CHK("volt r", 16'h001f, voltage_control)
		`CHK("rate r", 16'h0002, conversion_rate)
	endtask
	task automatic t_strap;
		@(negedge ref_clk) addr_strap = 1;
		repeat (4) @(negedge ref_clk);
		`CHK("sel hi", 3'h7, address_select_field)
		i_host.wr(6'h00, 16'h0000);
		i_host.rd(6'h00, v);
		`CHK("devnum ro", 16'h0007, v)
		addr_strap = 0;
		repeat (4) @(negedge ref_clk);
		`CHK("sel lo", 3'h1, address_select_field)
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk) rst = 0;
		t_power;
		t_soft;
		t_strap;
		conclude;
	end
endmodule // testbench
`default_nettype wire
